//--- verilog/pif_cfg.svh
// Constants for the peripheral interrupt flag register block
//
// Overview of operation
// - Each peripheral source has its own pending flag that can be read and cleared alone.
// - A flag is set by its event regardless of any enable bit, the global one included.
// - The flag register sits at offset 0x0c, bits 7..0 parallel, conv, rx, tx, sync, ccp, t2, t1.
// - All flags reset to zero; bits 5 and 4 are read-only, the other six read/write.
// - Bit 7 sets on a completed parallel port access and only software clears it.
// - Bit 4 is set when the transmit buffer empties and cleared by loading transmit data.
// - Bit 0 sets on timer1 overflow and stays set until software clears it.
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH

// Register byte offsets
`define PIF_OFS_FLAGS    8'h0c
`define PIF_OFS_MASK     8'h10
`define PIF_OFS_STATUS   8'h14
`define PIF_OFS_RX_DATA  8'h18
`define PIF_OFS_TX_DATA  8'h1c

// Flag bit positions
`define PIF_BIT_PARALLEL 7
`define PIF_BIT_CONV     6
`define PIF_BIT_RX_FULL  5
`define PIF_BIT_TX_EMPTY 4
`define PIF_BIT_SYNC     3
`define PIF_BIT_CCP      2
`define PIF_BIT_TIMER2   1
`define PIF_BIT_TIMER1   0

// Reset values and access masks
`define PIF_FLAGS_RESET  8'h00
`define PIF_FLAGS_RW     8'hcf
`define PIF_MASK_RESET   8'h00

// Bus responses
`define PIF_RESP_OKAY    2'h0
`define PIF_RESP_SLVERR  2'h2

`endif

//--- verilog/pif_pkg.sv
// Types shared by the peripheral interrupt flag block
`default_nettype none
package pif_pkg;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    PIF_SEL_NONE,
    PIF_SEL_FLAGS,
    PIF_SEL_MASK,
    PIF_SEL_STATUS,
    PIF_SEL_RX_DATA,
    PIF_SEL_TX_DATA
  } pif_sel_t;

  // Bus slave state
  typedef struct packed {
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } pif_bus_t;

  // Flag block state
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic       tx_load;
  } pif_core_t;

endpackage
`default_nettype wire

//--- verilog/pif_axil_slave.sv
// AXI4-Lite slave front end turning bus transfers into one-cycle register requests
`include "pif_cfg.svh"
`default_nettype none
module pif_axil_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_req,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic             rd_req,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);

  pif_pkg::pif_bus_t bus_reg;
  pif_pkg::pif_bus_t bus_next;

  // Handshakes and requests are plain gates; kept out of the state process so the
  // register side can answer in the same cycle without a false loop through it
  assign awready = !bus_reg.aw_held && !bus_reg.bvalid;
  assign wready  = !bus_reg.w_held && !bus_reg.bvalid;
  assign arready = !bus_reg.rvalid;
  assign wr_addr = bus_reg.aw_held ? bus_reg.aw_addr : awaddr;
  assign wr_data = bus_reg.w_held ? bus_reg.w_data : wdata;
  assign wr_strb = bus_reg.w_held ? bus_reg.w_strb : wstrb;
  assign wr_req  = (bus_reg.aw_held || awvalid) && (bus_reg.w_held || wvalid) && !bus_reg.bvalid;
  assign rd_req  = arvalid && arready;
  assign rd_addr = araddr;

  // Address and data may arrive in either order; each is parked until both are here
  always_comb begin
    bus_next = bus_reg;
    if (awvalid && awready) begin
      bus_next.aw_held = 1'b1;
      bus_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      bus_next.w_held = 1'b1;
      bus_next.w_data = wdata;
      bus_next.w_strb = wstrb;
    end
    if (bus_reg.bvalid && bready) begin
      bus_next.bvalid = 1'b0;
    end
    // Write happens in the cycle the second half arrives; answer next cycle
    if (wr_req) begin
      bus_next.aw_held = 1'b0;
      bus_next.w_held  = 1'b0;
      bus_next.bvalid  = 1'b1;
      bus_next.bresp   = wr_ok ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
    end
    if (bus_reg.rvalid && rready) begin
      bus_next.rvalid = 1'b0;
    end
    // Read data is captured at the handshake so read side effects fire once
    if (rd_req) begin
      bus_next.rvalid = 1'b1;
      bus_next.rdata  = rd_data;
      bus_next.rresp  = rd_ok ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_reg <= '0;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // Outputs straight from flip-flops
  assign bvalid = bus_reg.bvalid;
  assign bresp  = bus_reg.bresp;
  assign rvalid = bus_reg.rvalid;
  assign rresp  = bus_reg.rresp;
  assign rdata  = bus_reg.rdata;

endmodule
`default_nettype wire

//--- verilog/pif_flags.sv
// Peripheral interrupt flag register with event status, mask and serial data registers
`include "pif_cfg.svh"
`default_nettype none
module pif_flags (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        parallel_access_done,
  input  wire logic        conversion_done,
  input  wire logic        sync_serial_event,
  input  wire logic        capture_compare_event,
  input  wire logic        timer2_match,
  input  wire logic        timer1_overflow,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        tx_byte_taken,
  output logic [7:0]       tx_byte,
  output logic             tx_load,
  output logic [7:0]       peripheral_irq_flags,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus front end

  logic        wr_req;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic        rd_req;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;

  pif_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_req  (wr_req),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_req  (rd_req),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // Address decode shared by reads and writes
  function automatic pif_pkg::pif_sel_t decode(input logic [7:0] addr);
    case (addr)
      `PIF_OFS_FLAGS:   decode = pif_pkg::PIF_SEL_FLAGS;
      `PIF_OFS_MASK:    decode = pif_pkg::PIF_SEL_MASK;
      `PIF_OFS_STATUS:  decode = pif_pkg::PIF_SEL_STATUS;
      `PIF_OFS_RX_DATA: decode = pif_pkg::PIF_SEL_RX_DATA;
      `PIF_OFS_TX_DATA: decode = pif_pkg::PIF_SEL_TX_DATA;
      default:          decode = pif_pkg::PIF_SEL_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Flag logic

  pif_pkg::pif_core_t core_reg;
  pif_pkg::pif_core_t core_next;
  pif_pkg::pif_sel_t  wr_sel;
  pif_pkg::pif_sel_t  rd_sel;
  logic [7:0]         set_vec;
  logic               wr_lane0;

  // One set line per source, no enable gating anywhere
  assign set_vec = {parallel_access_done, conversion_done, rx_byte_valid, tx_byte_taken,
                    sync_serial_event, capture_compare_event, timer2_match, timer1_overflow};

  assign wr_sel   = decode(wr_addr);
  assign rd_sel   = decode(rd_addr);
  assign wr_lane0 = wr_req && wr_strb[0];
  assign wr_ok    = wr_sel != pif_pkg::PIF_SEL_NONE;
  assign rd_ok    = rd_sel != pif_pkg::PIF_SEL_NONE;

  // Read mux, upper bits read as zero
  always_comb begin
    case (rd_sel)
      pif_pkg::PIF_SEL_FLAGS:   rd_data = {24'h000000, core_reg.flags};
      pif_pkg::PIF_SEL_MASK:    rd_data = {24'h000000, core_reg.mask};
      pif_pkg::PIF_SEL_STATUS:  rd_data = {24'h000000, core_reg.status};
      pif_pkg::PIF_SEL_RX_DATA: rd_data = {24'h000000, core_reg.rx_data};
      pif_pkg::PIF_SEL_TX_DATA: rd_data = {24'h000000, core_reg.tx_data};
      default:                  rd_data = 32'h00000000;
    endcase
  end

  // Clears first, then sets, so an event in a clearing cycle is never lost
  always_comb begin
    core_next         = core_reg;
    core_next.tx_load = 1'b0;
    if (wr_lane0 && wr_sel == pif_pkg::PIF_SEL_FLAGS) begin
      // Receive and transmit bits follow the serial buffers, not software
      core_next.flags = (wr_data[7:0] & `PIF_FLAGS_RW) | (core_reg.flags & ~`PIF_FLAGS_RW);
    end
    if (wr_lane0 && wr_sel == pif_pkg::PIF_SEL_MASK) begin
      core_next.mask = wr_data[7:0];
    end
    if (wr_lane0 && wr_sel == pif_pkg::PIF_SEL_TX_DATA) begin
      core_next.tx_data                  = wr_data[7:0];
      core_next.tx_load                  = 1'b1;
      core_next.flags[`PIF_BIT_TX_EMPTY] = 1'b0;
    end
    if (rd_req && rd_sel == pif_pkg::PIF_SEL_RX_DATA) begin
      core_next.flags[`PIF_BIT_RX_FULL] = 1'b0;
    end
    if (rd_req && rd_sel == pif_pkg::PIF_SEL_STATUS) begin
      core_next.status = 8'h00;
    end
    if (rx_byte_valid) begin
      core_next.rx_data = rx_byte;
    end
    // Parallel, timer1 and the rest stay set until software clears
    core_next.flags  = core_next.flags | set_vec;
    core_next.status = core_next.status | set_vec;
  end

  // State register, all flags zero after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_reg       <= '0;
      core_reg.flags <= `PIF_FLAGS_RESET;
      core_reg.mask  <= `PIF_MASK_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  // Outputs
  assign peripheral_irq_flags = core_reg.flags;
  assign tx_byte              = core_reg.tx_data;
  assign tx_load              = core_reg.tx_load;
  assign irq                  = |(core_reg.status & core_reg.mask);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic wr_flags;
  logic rd_rx;
  assign wr_flags = wr_lane0 && wr_sel == pif_pkg::PIF_SEL_FLAGS;
  assign rd_rx    = rd_req && rd_sel == pif_pkg::PIF_SEL_RX_DATA;

  property p_set_any;
    @(posedge aclk) disable iff (!aresetn)
      (set_vec != 8'h00) |=> ((core_reg.flags & $past(set_vec)) == $past(set_vec));
  endproperty
  a_set_any: assert property (p_set_any) else $error("event did not set its flag");

  property p_quiet_stable;
    @(posedge aclk) disable iff (!aresetn)
      (set_vec == 8'h00 && !wr_req && !rd_req) |=> $stable(core_reg.flags);
  endproperty
  a_quiet_stable: assert property (p_quiet_stable) else $error("flag moved without cause");

  property p_read_flags;
    @(posedge aclk) disable iff (!aresetn)
      (rd_req && rd_addr == `PIF_OFS_FLAGS) |=> (rvalid && rdata == {24'h000000, $past(core_reg.flags)});
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("flag read mismatch");

  property p_ro_bits;
    @(posedge aclk) disable iff (!aresetn)
      (wr_flags && !rx_byte_valid && !tx_byte_taken && !rd_rx)
        |=> core_reg.flags[5:4] == $past(core_reg.flags[5:4]);
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("software changed read-only bits");

  property p_parallel_hold;
    @(posedge aclk) disable iff (!aresetn)
      $fell(core_reg.flags[`PIF_BIT_PARALLEL]) |-> $past(wr_flags);
  endproperty
  a_parallel_hold: assert property (p_parallel_hold) else $error("parallel flag self-cleared");

  property p_tx_clear;
    @(posedge aclk) disable iff (!aresetn)
      (wr_lane0 && wr_sel == pif_pkg::PIF_SEL_TX_DATA && !tx_byte_taken)
        |=> (!core_reg.flags[`PIF_BIT_TX_EMPTY] && tx_load) ##1 !tx_load;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("transmit load did not clear flag");

  property p_rx_clear;
    @(posedge aclk) disable iff (!aresetn)
      (rd_rx && !rx_byte_valid) |=> !core_reg.flags[`PIF_BIT_RX_FULL];
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive read did not clear flag");

  property p_timer1_hold;
    @(posedge aclk) disable iff (!aresetn)
      timer1_overflow ##1 (!wr_flags [*3]) |=> core_reg.flags[`PIF_BIT_TIMER1];
  endproperty
  a_timer1_hold: assert property (p_timer1_hold) else $error("timer1 flag lost");

  property p_irq_follow;
    @(posedge aclk) disable iff (!aresetn)
      (set_vec != 8'h00 && (set_vec & core_reg.mask) != 8'h00 && !wr_req) |=> irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("unmasked event raised no interrupt");

  c_parallel: cover property (@(posedge aclk) disable iff (!aresetn)
    parallel_access_done ##[1:20] wr_flags);
  c_serial: cover property (@(posedge aclk) disable iff (!aresetn) tx_load ##[1:50] tx_byte_taken);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));

endmodule
`default_nettype wire

//--- test/pif_periph_model.sv
// Peripheral-side model: event pulses, receiver delivery and transmitter drain
`default_nettype none
module pif_periph_model (
  input  wire logic       aclk,
  input  wire logic       tx_load,
  output logic [5:0]      ev_pulse,
  output logic            rx_byte_valid,
  output logic [7:0]      rx_byte,
  output logic            tx_byte_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] tx_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Idle values; the data line shows junk outside a delivery
  initial begin
    ev_pulse = 6'h00;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    tx_byte_taken = 1'b0;
    tx_cnt = 3'h0;
  end

  // One-cycle event pulse, index 5..0 = parallel, conv, sync, ccp, t2, t1
  task automatic fire(input int idx);
    @(posedge aclk);
    ev_pulse <= 6'h01 << idx;
    @(posedge aclk);
    ev_pulse <= 6'h00;
  endtask

  // Receiver hands over one byte, then the data line is inverted
  task automatic deliver(input logic [7:0] b);
    @(posedge aclk);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    @(posedge aclk);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~b;
  endtask

  // Transmitter drains a loaded byte a few cycles later, as a slow line would
  always @(posedge aclk) begin
    tx_byte_taken <= 1'b0;
    if (tx_load === 1'b1) begin
      tx_cnt <= 3'h4;
    end else if (tx_cnt != 3'h0) begin
      tx_cnt <= tx_cnt - 3'h1;
      if (tx_cnt == 3'h1) begin
        tx_byte_taken <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the peripheral interrupt flag block
`include "pif_cfg.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx_byte_valid, tx_byte_taken;
  logic        tx_load, irq;
  logic [7:0]  awaddr, araddr, rx_byte, tx_byte, peripheral_irq_flags;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, strb;
  logic [1:0]  bresp, rresp, resp;
  logic [5:0]  ev_pulse;
  logic [31:0] rd;
  int          miscompares, num_checks, cycles, loads;

  pif_flags uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .parallel_access_done(ev_pulse[5]), .conversion_done(ev_pulse[4]),
    .sync_serial_event(ev_pulse[3]), .capture_compare_event(ev_pulse[2]),
    .timer2_match(ev_pulse[1]), .timer1_overflow(ev_pulse[0]),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .tx_byte_taken(tx_byte_taken),
    .tx_byte(tx_byte), .tx_load(tx_load), .peripheral_irq_flags(peripheral_irq_flags),
    .irq(irq));
  pif_periph_model model (.aclk(aclk), .tx_load(tx_load), .ev_pulse(ev_pulse),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .tx_byte_taken(tx_byte_taken));

  ////////////////////////////////////////////////////////////////////////
  // Clock, load counter and hang guard
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (tx_load === 1'b1) loads++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus master: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    wstrb <= strb;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp; bready <= 1'b0; break;
      end
    end
    #1;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata; r = rresp; rready <= 1'b0; break;
      end
    end
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Each of the six event sources sets its own bit with the mask at zero, then clears alone
  task automatic t_events();
    logic [7:0] exp;
    int pos;
    exp = 8'h00;
    for (int i = 0; i < 6; i++) begin
      pos = (i >= 4) ? i + 2 : i;
      model.fire(i);
      #1;
      exp[pos] = 1'b1;
      chk("flags set", peripheral_irq_flags, exp);
      chk("irq masked", irq, 1'b0);
    end
    repeat (3) @(posedge aclk);
    #1;
    chk("flags stay", peripheral_irq_flags, 8'hcf);
    for (int i = 0; i < 6; i++) begin
      pos = (i >= 4) ? i + 2 : i;
      exp[pos] = 1'b0;
      axw(`PIF_OFS_FLAGS, {24'h0, exp}, resp);
      chk("flag clear", peripheral_irq_flags, exp);
    end
    axr(`PIF_OFS_STATUS, rd, resp);
  endtask

  // Read-only bits ignore a write of all ones
  task automatic t_access();
    axw(`PIF_OFS_FLAGS, 32'h0000_00ff, resp);
    axr(`PIF_OFS_FLAGS, rd, resp);
    chk("rw bits", rd, {24'h0, `PIF_FLAGS_RW});
    chk("flags resp", resp, `PIF_RESP_OKAY);
    axw(`PIF_OFS_FLAGS, 32'h0, resp);
    chk("flags zero", peripheral_irq_flags, 8'h00);
    // A write without the low byte lane must leave the flags alone
    strb = 4'he;
    axw(`PIF_OFS_FLAGS, 32'h0000_00ff, resp);
    strb = 4'hf;
    chk("lane0 off", peripheral_irq_flags, 8'h00);
    chk("lane0 resp", resp, `PIF_RESP_OKAY);
    axr(8'h40, rd, resp);
    chk("unmapped read", resp, `PIF_RESP_SLVERR);
    axw(8'h44, 32'hff, resp);
    chk("unmapped write", resp, `PIF_RESP_SLVERR);
    axr(`PIF_OFS_STATUS, rd, resp);
  endtask

  // Receive flag follows unread data
  task automatic t_rx();
    model.deliver(8'h5a);
    #1;
    chk("rx full", peripheral_irq_flags[5], 1'b1);
    axr(`PIF_OFS_RX_DATA, rd, resp);
    chk("rx data", rd, 32'h0000_005a);
    chk("rx drained", peripheral_irq_flags[5], 1'b0);
  endtask

  // Transmit flag: set when drained, cleared by loading again
  task automatic t_tx();
    loads = 0;
    axw(`PIF_OFS_TX_DATA, 32'h0000_00a5, resp);
    chk("tx byte", tx_byte, 8'ha5);
    repeat (8) @(posedge aclk);
    #1;
    chk("tx empty", peripheral_irq_flags[4], 1'b1);
    axw(`PIF_OFS_TX_DATA, 32'h0000_003c, resp);
    chk("tx full", peripheral_irq_flags[4], 1'b0);
    chk("tx byte 2", tx_byte, 8'h3c);
    repeat (8) @(posedge aclk);
    #1;
    chk("tx loads", loads, 2);
    axr(`PIF_OFS_STATUS, rd, resp);
  endtask

  // Interrupt raised, masked, unmasked and cleared by a status read
  task automatic t_irq();
    axr(`PIF_OFS_STATUS, rd, resp);
    axw(`PIF_OFS_MASK, 32'h0000_0001, resp);
    chk("irq idle", irq, 1'b0);
    model.fire(0);
    #1;
    chk("irq up", irq, 1'b1);
    axw(`PIF_OFS_MASK, 32'h0, resp);
    chk("irq masked", irq, 1'b0);
    chk("t1 masked", peripheral_irq_flags[0], 1'b1);
    axw(`PIF_OFS_MASK, 32'h0000_0001, resp);
    chk("irq again", irq, 1'b1);
    axr(`PIF_OFS_STATUS, rd, resp);
    chk("status", rd, 32'h0000_0001);
    chk("irq cleared", irq, 1'b0);
    chk("t1 stays", peripheral_irq_flags[0], 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'hf;
    strb = 4'hf;
    miscompares = 0; num_checks = 0; cycles = 0; loads = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk("reset flags", peripheral_irq_flags, `PIF_FLAGS_RESET);
    chk("reset irq", irq, 1'b0);
    axr(`PIF_OFS_MASK, rd, resp);
    chk("reset mask", rd, {24'h0, `PIF_MASK_RESET});
    t_events();
    t_access();
    t_rx();
    t_tx();
    t_irq();
    tally_and_finish();
  end
endmodule
`default_nettype wire
